//--- rtl/gdc_config_bank.sv
// Gate-driver configuration bank with overcurrent fault handling.
// Assumes comparator inputs arrive asynchronously and the register
// port and fault clear come from logic on ref_clk_i.
`timescale 1ns/1ns
module gdc_config_bank
  import gdc_pkg::*;
#(
  parameter int RETRY_SHORT_CYC = GDC_RETRY_SHORT_CYC,
  parameter int RETRY_LONG_CYC = GDC_RETRY_LONG_CYC
) (
  // Clock and reset
  input wire logic ref_clk_i,
  input wire logic reset_i,
  // Register port
  input wire logic [7:0] reg_addr_i,
  input wire logic reg_wr_i,
  input wire logic [31:0] reg_wdata_i,
  input wire logic reg_rd_i,
  output logic [31:0] reg_rdata_o,
  output logic reg_rvalid_o,
  // Analog comparator flags and fault clear
  input wire logic overcurrent_detect_i,
  input wire logic overvoltage_detect_i,
  input wire logic thermal_warning_i,
  input wire logic fault_clear_i,
  // Fault and drive control
  output logic fault_out_n_o,
  output logic drive_enable_o,
  output logic overcurrent_fault_o,
  // Analog configuration
  output logic overvoltage_level_select_o,
  output logic overcurrent_trip_level_o,
  output logic demag_threshold_low_side_o,
  output logic demag_threshold_high_side_o,
  output logic sync_rectify_enable_o,
  output logic async_rectify_enable_o,
  output logic [1:0] sense_amp_gain_o,
  output logic delay_comp_enable_o,
  output logic regulator_enable_o
);

  localparam int RW = $clog2(RETRY_LONG_CYC + 1);

  // Parameter sanity
  if (RETRY_SHORT_CYC < 1 || RETRY_SHORT_CYC > RETRY_LONG_CYC) begin : g_bad_retry
    $error("retry counts must satisfy 1 <= short <= long");
  end

  typedef struct packed {
    logic [31:0] prot_cfg;
    logic [31:0] buck_cfg;
    logic [2:0] oc_sync;
    logic [2:0] ov_sync;
    logic [2:0] ot_sync;
    logic oc_f;
    logic ov_f;
    logic ot_f;
    logic [8:0] deg_cnt;
    logic [RW-1:0] retry_cnt;
    gdc_ocp_state_t st;
    logic ovp_flt;
    logic oc_rep;
    logic fault_n;
    logic drive_en;
    logic [31:0] rdata;
    logic rvalid;
  } gdc_state_t;

  gdc_state_t q;
  gdc_state_t d;
  logic [8:0] deg_tgt;
  logic [RW-1:0] retry_tgt;
  logic [1:0] mode;
  logic oc_hit;

  // Field decode from the stored configuration
  always_comb begin
    mode = q.prot_cfg[GDC_OVERCURRENT_FAULT_MODE_LSB +: 2];
    unique case (q.prot_cfg[GDC_OVERCURRENT_DEGLITCH_LSB +: 2])
      2'h0: deg_tgt = GDC_DEG0_CYC;
      2'h1: deg_tgt = GDC_DEG1_CYC;
      2'h2: deg_tgt = GDC_DEG2_CYC;
      default: deg_tgt = GDC_DEG3_CYC;
    endcase
    retry_tgt = q.prot_cfg[GDC_OVERCURRENT_RETRY_TIME_BIT] ? RW'(RETRY_LONG_CYC) : RW'(RETRY_SHORT_CYC);
    oc_hit = q.oc_f && (q.deg_cnt == deg_tgt);
  end

  // Next-state logic
  always_comb begin
    d = q;
    // Register writes; every bit stored, parity and reserved included
    if (reg_wr_i && reg_addr_i == GDC_PROT_CFG_ADDR) begin
      d.prot_cfg = reg_wdata_i;
    end
    if (reg_wr_i && reg_addr_i == GDC_BUCK_CFG_ADDR) begin
      d.buck_cfg = reg_wdata_i;
    end
    // Register reads; unmapped addresses read zero
    d.rvalid = reg_rd_i;
    if (reg_rd_i) begin
      if (reg_addr_i == GDC_PROT_CFG_ADDR) begin
        d.rdata = q.prot_cfg;
      end else if (reg_addr_i == GDC_BUCK_CFG_ADDR) begin
        d.rdata = q.buck_cfg;
      end else begin
        d.rdata = 32'h00000000;
      end
    end
    // Three-stage synchronisers; accept a change when stages two and three agree
    // Comparator edges are asynchronous, so the first stage may go metastable;
    // only the settled second and third stages feed the filtered flags.
    d.oc_sync = {q.oc_sync[1:0], overcurrent_detect_i};
    d.ov_sync = {q.ov_sync[1:0], overvoltage_detect_i};
    d.ot_sync = {q.ot_sync[1:0], thermal_warning_i};
    if (q.oc_sync[1] == q.oc_sync[2]) begin
      d.oc_f = q.oc_sync[2];
    end
    if (q.ov_sync[1] == q.ov_sync[2]) begin
      d.ov_f = q.ov_sync[2];
    end
    if (q.ot_sync[1] == q.ot_sync[2]) begin
      d.ot_f = q.ot_sync[2];
    end
    // Deglitch counter saturates at the selected qualify time
    // Saturating keeps a lasting overcurrent qualified, so a clear or a retry
    // end with the fault still present trips again at once.
    if (!q.oc_f) begin
      d.deg_cnt = 9'h000;
    end else if (q.deg_cnt < deg_tgt) begin
      d.deg_cnt = q.deg_cnt + 9'h001;
    end
    // Overcurrent protection state machine
    // Only the two protective modes leave the run state; report and ignore
    // modes never stop the bridge. A mode change while latched keeps the
    // fault until it is cleared.
    unique case (q.st)
      GDC_ST_RUN: begin
        if (oc_hit && mode == GDC_MODE_LATCH) begin
          d.st = GDC_ST_LATCHED;
        end else if (oc_hit && mode == GDC_MODE_RETRY) begin
          d.st = GDC_ST_RETRY;
          d.retry_cnt = '0;
        end
      end
      GDC_ST_LATCHED: begin
        if (fault_clear_i) begin
          d.st = GDC_ST_RUN;
        end
      end
      GDC_ST_RETRY: begin
        if (q.retry_cnt >= retry_tgt - RW'(1)) begin
          d.st = GDC_ST_RUN;
          d.retry_cnt = '0;
        end else begin
          d.retry_cnt = q.retry_cnt + RW'(1);
        end
      end
      default: d.st = GDC_ST_RUN;
    endcase
    // Fault report: protective modes while in fault, report mode while qualified
    // Protective modes use the next state so the flag and the drive enable move together.
    unique case (mode)
      GDC_MODE_REPORT: d.oc_rep = oc_hit;
      GDC_MODE_OFF: d.oc_rep = 1'b0;
      default: d.oc_rep = (d.st != GDC_ST_RUN);
    endcase
    if (mode != GDC_MODE_LATCH && mode != GDC_MODE_RETRY && q.st == GDC_ST_LATCHED) begin
      d.oc_rep = 1'b1;
    end
    // Overvoltage shuts the bridge only while enabled
    d.ovp_flt = q.ov_f && q.prot_cfg[GDC_OVERVOLTAGE_PROTECT_ENABLE_BIT];
    d.drive_en = (d.st == GDC_ST_RUN) && !d.ovp_flt;
    d.fault_n = !(d.ovp_flt || d.oc_rep || (q.ot_f && q.prot_cfg[GDC_THERMAL_WARNING_REPORT_BIT]));
  end

  // State register
  // Synchronous reset; config words reload their documented defaults and
  // the bridge comes up enabled with no fault shown.
  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      q <= '0;
      q.prot_cfg <= GDC_PROT_CFG_RST;
      q.buck_cfg <= GDC_BUCK_CFG_RST;
      q.st <= GDC_ST_RUN;
      q.fault_n <= 1'b1;
      q.drive_en <= 1'b1;
    end else begin
      q <= d;
    end
  end

  // Outputs straight from stored state
  assign reg_rdata_o = q.rdata;
  assign reg_rvalid_o = q.rvalid;
  assign fault_out_n_o = q.fault_n;
  assign drive_enable_o = q.drive_en;
  assign overcurrent_fault_o = q.oc_rep;
  assign overvoltage_level_select_o = q.prot_cfg[GDC_OVP_LEVEL_BIT];
  assign overcurrent_trip_level_o = q.prot_cfg[GDC_OVERCURRENT_TRIP_LEVEL_BIT];
  assign demag_threshold_low_side_o = q.prot_cfg[GDC_DEMAG_LS_BIT];
  assign demag_threshold_high_side_o = q.prot_cfg[GDC_DEMAG_HS_BIT];
  assign sync_rectify_enable_o = q.prot_cfg[GDC_SYNC_RECT_BIT];
  assign async_rectify_enable_o = q.prot_cfg[GDC_ASYNC_RECT_BIT];
  assign sense_amp_gain_o = q.prot_cfg[GDC_GAIN_LSB +: 2];
  assign delay_comp_enable_o = q.buck_cfg[GDC_DELAY_COMP_BIT];
  assign regulator_enable_o = !q.buck_cfg[GDC_REGULATOR_DISABLE_BIT];

  // Checks
  // All checks run on ref_clk_i and are quiet while reset is held.
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (reset_i);

  AST_PROT_RESET: assert property ($fell(reset_i) |-> reg_rdata_o == 32'h00000000 && q.prot_cfg == GDC_PROT_CFG_RST)
    else $error("protection config reset value wrong");
  AST_BUCK_RESET: assert property ($fell(reset_i) |-> q.buck_cfg == GDC_BUCK_CFG_RST && regulator_enable_o)
    else $error("buck config reset value wrong");
  AST_OVP_GATED: assert property (!q.prot_cfg[18] |=> !q.ovp_flt)
    else $error("overvoltage acted while disabled");
  AST_OVP_DRIVE: assert property ((q.ov_f && q.prot_cfg[18]) |=> !drive_enable_o && !fault_out_n_o)
    else $error("overvoltage did not stop the drive");
  AST_OTW_REPORT: assert property ((q.ot_f && q.prot_cfg[16]) |=> !fault_out_n_o)
    else $error("thermal warning not reported");
  AST_DEGLITCH: assert property ($rose(q.st == GDC_ST_LATCHED) |-> $past(q.oc_f, 50))
    else $error("overcurrent latched before least deglitch time");
  AST_RETRY_LEN: assert property ($fell(q.st == GDC_ST_RETRY) |-> $past(q.retry_cnt) == $past(retry_tgt) - RW'(1))
    else $error("retry wait length wrong");
  AST_RETRY_OFF: assert property (q.st == GDC_ST_RETRY |-> !drive_enable_o)
    else $error("drive enabled during retry");
  AST_LATCH_HOLD: assert property ((q.st == GDC_ST_LATCHED && !fault_clear_i) |=> q.st == GDC_ST_LATCHED && !drive_enable_o)
    else $error("latched fault dropped without clear");
  AST_MODE_OFF: assert property ((mode == 2'h3 && $past(mode) == 2'h3 && q.st == GDC_ST_RUN) |=> !overcurrent_fault_o)
    else $error("overcurrent reported in ignore mode");
  AST_SYNC_RECT: assert property ((reg_wr_i && reg_addr_i == 8'hAC) |=> sync_rectify_enable_o == $past(reg_wdata_i[3]))
    else $error("sync rectify enable not taken from write");
  AST_REGULATOR_DISABLE: assert property ((reg_wr_i && reg_addr_i == 8'hAE && reg_wdata_i[20]) |=> !regulator_enable_o)
    else $error("buck not disabled by write");


  // Writes land whole in the stored words, parity and reserved bits included
  AST_PROT_STORE: assert property ((reg_wr_i && reg_addr_i == GDC_PROT_CFG_ADDR) |=> q.prot_cfg == $past(reg_wdata_i))
    else $error("protection config write not stored whole");
  AST_BUCK_STORE: assert property ((reg_wr_i && reg_addr_i == GDC_BUCK_CFG_ADDR) |=> q.buck_cfg == $past(reg_wdata_i))
    else $error("buck config write not stored whole");

  // Analog settings follow the written fields one edge later
  AST_LEVEL_SEL: assert property ((reg_wr_i && reg_addr_i == GDC_PROT_CFG_ADDR)
    |=> overvoltage_level_select_o == $past(reg_wdata_i[GDC_OVP_LEVEL_BIT]))
    else $error("overvoltage level select not taken from write");
  AST_TRIP_LEVEL: assert property ((reg_wr_i && reg_addr_i == GDC_PROT_CFG_ADDR)
    |=> overcurrent_trip_level_o == $past(reg_wdata_i[GDC_OVERCURRENT_TRIP_LEVEL_BIT]))
    else $error("trip level not taken from write");
  AST_DEMAG_LS: assert property ((reg_wr_i && reg_addr_i == GDC_PROT_CFG_ADDR)
    |=> demag_threshold_low_side_o == $past(reg_wdata_i[GDC_DEMAG_LS_BIT]))
    else $error("low-side demag threshold not taken from write");
  AST_DEMAG_HS: assert property ((reg_wr_i && reg_addr_i == GDC_PROT_CFG_ADDR)
    |=> demag_threshold_high_side_o == $past(reg_wdata_i[GDC_DEMAG_HS_BIT]))
    else $error("high-side demag threshold not taken from write");
  AST_ASYNC_RECT: assert property ((reg_wr_i && reg_addr_i == GDC_PROT_CFG_ADDR)
    |=> async_rectify_enable_o == $past(reg_wdata_i[GDC_ASYNC_RECT_BIT]))
    else $error("async rectify enable not taken from write");
  AST_GAIN: assert property ((reg_wr_i && reg_addr_i == GDC_PROT_CFG_ADDR)
    |=> sense_amp_gain_o == $past(reg_wdata_i[GDC_GAIN_LSB +: 2]))
    else $error("sense amp gain not taken from write");
  AST_DELAY_COMP: assert property ((reg_wr_i && reg_addr_i == GDC_BUCK_CFG_ADDR)
    |=> delay_comp_enable_o == $past(reg_wdata_i[GDC_DELAY_COMP_BIT]))
    else $error("delay compensation enable not taken from write");
  AST_BUCK_EN: assert property ((reg_wr_i && reg_addr_i == GDC_BUCK_CFG_ADDR && !reg_wdata_i[GDC_REGULATOR_DISABLE_BIT])
    |=> regulator_enable_o)
    else $error("buck not enabled by write");

  // Read port answers one edge later with a single valid pulse
  AST_RVALID: assert property (reg_rd_i |=> reg_rvalid_o)
    else $error("read not answered");
  AST_RVALID_PULSE: assert property (!reg_rd_i |=> !reg_rvalid_o)
    else $error("read valid without a read");
  AST_UNMAPPED_RD: assert property ((reg_rd_i && reg_addr_i != GDC_PROT_CFG_ADDR && reg_addr_i != GDC_BUCK_CFG_ADDR)
    |=> reg_rdata_o == 32'h00000000)
    else $error("unmapped read not zero");

  // Fault machine transitions
  AST_OC_FILTER: assert property ($changed(q.oc_f) |-> q.oc_f == $past(q.oc_sync[2]))
    else $error("overcurrent flag changed without synchroniser agreement");
  AST_LATCH_ENTRY: assert property ((q.st == GDC_ST_RUN && oc_hit && mode == GDC_MODE_LATCH) |=> q.st == GDC_ST_LATCHED)
    else $error("qualified overcurrent did not latch");
  AST_RETRY_ENTRY: assert property ((q.st == GDC_ST_RUN && oc_hit && mode == GDC_MODE_RETRY) |=> q.st == GDC_ST_RETRY)
    else $error("qualified overcurrent did not start retry");
  AST_REPORT_DRIVE: assert property ((mode == GDC_MODE_REPORT && q.st == GDC_ST_RUN
    && !(q.ov_f && q.prot_cfg[GDC_OVERVOLTAGE_PROTECT_ENABLE_BIT])) |=> drive_enable_o)
    else $error("report-only mode stopped the drive");
  AST_LATCH_CLEAR: assert property ((q.st == GDC_ST_LATCHED && fault_clear_i) |=> q.st == GDC_ST_RUN)
    else $error("fault clear did not release latch");
  AST_RETRY_END: assert property ($fell(q.st == GDC_ST_RETRY) |-> q.st == GDC_ST_RUN)
    else $error("retry did not return to run");
  AST_OTW_QUIET: assert property ((!q.prot_cfg[GDC_THERMAL_WARNING_REPORT_BIT] && !q.ov_f && mode == GDC_MODE_OFF
    && q.st == GDC_ST_RUN) |=> fault_out_n_o)
    else $error("fault pin low with reporting disabled");

  COV_CLEAR: cover property (q.st == GDC_ST_LATCHED && fault_clear_i);
  COV_LATCH: cover property ($rose(q.st == GDC_ST_LATCHED));
  COV_RETRY_DONE: cover property ($fell(q.st == GDC_ST_RETRY));
  COV_REPORT: cover property (mode == GDC_MODE_REPORT && overcurrent_fault_o && drive_enable_o);
  COV_OVP: cover property (q.ovp_flt);

endmodule : gdc_config_bank

//--- include/gdc_pkg.sv
// Constants shared by the gate-driver configuration bank.
// Assumes a 250 MHz ref_clk_i and a byte-wide register address.
// How it works
// - First config register sits at ACh, resets to 00228000h.
// - Second config register sits at AEh, resets to 01200000h.
// - Overvoltage level bit picks 32 V or 20 V; enable bit gates protection.
// - Thermal warnings pull the fault output low only when bit 16 is set.
// - Overcurrent must persist 0.2, 0.6, 1.1 or 1.6 us before it counts.
// - Automatic retry waits 5 ms or 500 ms per the retry bit.
// - One bit selects the 16 A or 24 A overcurrent trip level.
// - Mode 0 latches overcurrent faults; mode 1 retries automatically.
// - Mode 2 only reports overcurrent; mode 3 ignores it entirely.
// - Low-side demag threshold bit: 100 mA or 150 mA.
// - High-side demag threshold bit, same coding: 100 mA or 150 mA.
// - Synchronous rectification runs only while bit 3 is set.
// - Asynchronous rectification runs only while bit 2 is set.
// - Two-bit gain code picks 0.15, 0.3, 0.6 or 1.2 V/A.
// - Delay compensation applies only while its enable bit is set.
// - Buck regulator runs while its disable bit is clear.
package gdc_pkg;
  // Register map
  localparam logic [7:0] GDC_PROT_CFG_ADDR = 8'hAC;
  localparam logic [7:0] GDC_BUCK_CFG_ADDR = 8'hAE;
  localparam logic [31:0] GDC_PROT_CFG_RST = 32'h00228000;
  localparam logic [31:0] GDC_BUCK_CFG_RST = 32'h01200000;
  // Protection register field positions
  localparam int GDC_OVP_LEVEL_BIT = 19;
  localparam int GDC_OVERVOLTAGE_PROTECT_ENABLE_BIT = 18;
  localparam int GDC_THERMAL_WARNING_REPORT_BIT = 16;
  localparam int GDC_OVERCURRENT_DEGLITCH_LSB = 12;
  localparam int GDC_OVERCURRENT_RETRY_TIME_BIT = 11;
  localparam int GDC_OVERCURRENT_TRIP_LEVEL_BIT = 10;
  localparam int GDC_OVERCURRENT_FAULT_MODE_LSB = 8;
  localparam int GDC_DEMAG_LS_BIT = 5;
  localparam int GDC_DEMAG_HS_BIT = 4;
  localparam int GDC_SYNC_RECT_BIT = 3;
  localparam int GDC_ASYNC_RECT_BIT = 2;
  localparam int GDC_GAIN_LSB = 0;
  // Buck/delay register field positions
  localparam int GDC_DELAY_COMP_BIT = 30;
  localparam int GDC_REGULATOR_DISABLE_BIT = 20;
  // Fault mode codes
  localparam logic [1:0] GDC_MODE_LATCH = 2'h0;
  localparam logic [1:0] GDC_MODE_RETRY = 2'h1;
  localparam logic [1:0] GDC_MODE_REPORT = 2'h2;
  localparam logic [1:0] GDC_MODE_OFF = 2'h3;
  // Timing
  localparam int GDC_CLK_PERIOD_NS = 4;
  localparam int GDC_DEG0_NS = 200;
  localparam int GDC_DEG1_NS = 600;
  localparam int GDC_DEG2_NS = 1100;
  localparam int GDC_DEG3_NS = 1600;
  localparam logic [8:0] GDC_DEG0_CYC = 9'((GDC_DEG0_NS + GDC_CLK_PERIOD_NS - 1) / GDC_CLK_PERIOD_NS);
  localparam logic [8:0] GDC_DEG1_CYC = 9'((GDC_DEG1_NS + GDC_CLK_PERIOD_NS - 1) / GDC_CLK_PERIOD_NS);
  localparam logic [8:0] GDC_DEG2_CYC = 9'((GDC_DEG2_NS + GDC_CLK_PERIOD_NS - 1) / GDC_CLK_PERIOD_NS);
  localparam logic [8:0] GDC_DEG3_CYC = 9'((GDC_DEG3_NS + GDC_CLK_PERIOD_NS - 1) / GDC_CLK_PERIOD_NS);
  localparam int GDC_RETRY_SHORT_MS = 5;
  localparam int GDC_RETRY_LONG_MS = 500;
  localparam int GDC_RETRY_SHORT_CYC = (GDC_RETRY_SHORT_MS * 1000000 + GDC_CLK_PERIOD_NS - 1) / GDC_CLK_PERIOD_NS;
  localparam int GDC_RETRY_LONG_CYC = (GDC_RETRY_LONG_MS * 1000000 + GDC_CLK_PERIOD_NS - 1) / GDC_CLK_PERIOD_NS;
  // Overcurrent protection states
  typedef enum logic [1:0] {
    GDC_ST_RUN,
    GDC_ST_LATCHED,
    GDC_ST_RETRY
  } gdc_ocp_state_t;
endpackage : gdc_pkg

//--- verif/tb.sv
// Self-checking bench for the gate-driver configuration bank.
// Assumes registered outputs on ref_clk_i and short retry parameters.
`timescale 1ns/1ns
module tb;
  import gdc_pkg::*;
  localparam int RS = 20;
  localparam int RL = 60;
  // Stimulus and observed signals
  logic ref_clk_i = 1'b0;
  logic reset_i = 1'b1;
  logic reg_wr_i = 1'b0;
  logic reg_rd_i = 1'b0;
  logic [7:0] reg_addr_i = 8'h00;
  logic [31:0] reg_wdata_i = 32'h00000000;
  logic [31:0] reg_rdata_o;
  logic [31:0] p;
  logic oc_i = 1'b0;
  logic ov_i = 1'b0;
  logic tw_i = 1'b0;
  logic clr_i = 1'b0;
  logic reg_rvalid_o, fault_out_n_o, drive_enable_o, overcurrent_fault_o;
  logic [7:0] cfg_o;
  logic delay_comp_enable_o, regulator_enable_o;
  int mismatches = 0;
  int checks_done = 0;
  int n;
  int deg_cyc [4] = '{GDC_DEG0_CYC, GDC_DEG1_CYC, GDC_DEG2_CYC, GDC_DEG3_CYC};

  gdc_config_bank #(.RETRY_SHORT_CYC(RS), .RETRY_LONG_CYC(RL)) gdc_config_bank_inst (
    .ref_clk_i(ref_clk_i), .reset_i(reset_i), .reg_addr_i(reg_addr_i), .reg_wr_i(reg_wr_i),
    .reg_wdata_i(reg_wdata_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .reg_rvalid_o(reg_rvalid_o),
    .overcurrent_detect_i(oc_i), .overvoltage_detect_i(ov_i), .thermal_warning_i(tw_i),
    .fault_clear_i(clr_i), .fault_out_n_o(fault_out_n_o), .drive_enable_o(drive_enable_o),
    .overcurrent_fault_o(overcurrent_fault_o), .overvoltage_level_select_o(cfg_o[7]),
    .overcurrent_trip_level_o(cfg_o[6]), .demag_threshold_low_side_o(cfg_o[5]),
    .demag_threshold_high_side_o(cfg_o[4]), .sync_rectify_enable_o(cfg_o[3]),
    .async_rectify_enable_o(cfg_o[2]), .sense_amp_gain_o(cfg_o[1:0]),
    .delay_comp_enable_o(delay_comp_enable_o), .regulator_enable_o(regulator_enable_o));

  // 250 MHz clock
  initial begin
    forever #2 ref_clk_i = ~ref_clk_i;
  end

  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      mismatches++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : cmp

  // Fault pin, drive enable, overcurrent flag
  task automatic st(input logic [2:0] exp);
    cmp({29'h0, fault_out_n_o, drive_enable_o, overcurrent_fault_o}, {29'h0, exp});
  endtask : st

  // Lands just after a rising edge
  task automatic tick(input int k);
    repeat (k) @(posedge ref_clk_i);
    #1;
  endtask : tick

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    reg_addr_i = a;
    reg_wdata_i = d;
    reg_wr_i = 1'b1;
    tick(1);
    reg_wr_i = 1'b0;
    tick(1);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    reg_addr_i = a;
    reg_rd_i = 1'b1;
    tick(1);
    cmp({31'h0, reg_rvalid_o}, 32'h00000001);
    cmp(reg_rdata_o, exp);
    reg_rd_i = 1'b0;
    tick(1);
  endtask : rd

  // Bounded wait on the drive enable
  task automatic wait_drive(input logic v, input int lim);
    n = 0;
    while (drive_enable_o !== v && n < lim) begin
      tick(1);
      n++;
    end
  endtask : wait_drive

  function automatic logic [31:0] pc(input logic [1:0] m, input logic [1:0] dg, input logic rt);
    pc = GDC_PROT_CFG_RST;
    pc[9:8] = m;
    pc[13:12] = dg;
    pc[11] = rt;
  endfunction : pc

  task automatic final_report;
    $display("checks_done=%0d mismatches=%0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : final_report

  // Main sequence
  initial begin
    tick(3);
    reset_i = 1'b0;
    st(3'b110);
    rd(GDC_PROT_CFG_ADDR, GDC_PROT_CFG_RST);
    rd(GDC_BUCK_CFG_ADDR, GDC_BUCK_CFG_RST);
    cmp({30'h0, delay_comp_enable_o, regulator_enable_o}, 32'h00000001);
    rd(8'hAD, 32'h00000000);
    wr(8'hAD, 32'hFFFFFFFF);
    rd(GDC_PROT_CFG_ADDR, GDC_PROT_CFG_RST);
    for (int i = 0; i < 2; i++) begin
      p = i ? 32'hA5A5A55A : 32'h5A5A5AA5;
      wr(GDC_PROT_CFG_ADDR, p);
      wr(GDC_BUCK_CFG_ADDR, p);
      rd(GDC_PROT_CFG_ADDR, p);
      rd(GDC_BUCK_CFG_ADDR, p);
      cmp({24'h0, cfg_o}, {24'h0, p[19], p[10], p[5], p[4], p[3], p[2], p[1:0]});
      cmp({30'h0, delay_comp_enable_o, regulator_enable_o}, {30'h0, p[30], ~p[20]});
    end
    // Deglitch codes with latched faults
    for (int k = 0; k < 4; k++) begin
      wr(GDC_PROT_CFG_ADDR, pc(GDC_MODE_LATCH, 2'(k), 1'b0));
      oc_i = 1'b1;
      tick(deg_cyc[k] - 6);
      oc_i = 1'b0;
      tick(12);
      st(3'b110);
      oc_i = 1'b1;
      wait_drive(1'b0, 450);
      cmp(32'(n >= deg_cyc[k] && n <= deg_cyc[k] + 10), 32'h00000001);
      oc_i = 1'b0;
      tick(20);
      st(3'b001);
      clr_i = 1'b1;
      tick(1);
      clr_i = 1'b0;
      tick(4);
      st(3'b110);
    end
    // Automatic retry, both retry times
    for (int r = 0; r < 2; r++) begin
      wr(GDC_PROT_CFG_ADDR, pc(GDC_MODE_RETRY, 2'h0, 1'(r)));
      oc_i = 1'b1;
      wait_drive(1'b0, 80);
      oc_i = 1'b0;
      st(3'b001);
      wait_drive(1'b1, 200);
      cmp(32'(n >= (r ? RL : RS) - 2 && n <= (r ? RL : RS) + 4), 32'h00000001);
      tick(2);
      st(3'b110);
    end
    // Report-only and ignore modes
    wr(GDC_PROT_CFG_ADDR, pc(GDC_MODE_REPORT, 2'h0, 1'b0));
    oc_i = 1'b1;
    tick(70);
    st(3'b011);
    oc_i = 1'b0;
    tick(10);
    st(3'b110);
    wr(GDC_PROT_CFG_ADDR, pc(GDC_MODE_OFF, 2'h0, 1'b0));
    oc_i = 1'b1;
    tick(70);
    st(3'b110);
    oc_i = 1'b0;
    // Thermal warning reporting gate
    tw_i = 1'b1;
    tick(10);
    st(3'b110);
    wr(GDC_PROT_CFG_ADDR, pc(GDC_MODE_OFF, 2'h0, 1'b0) | 32'h00010000);
    tick(10);
    cmp({31'h0, fault_out_n_o}, 32'h00000000);
    tw_i = 1'b0;
    wr(GDC_PROT_CFG_ADDR, pc(GDC_MODE_OFF, 2'h0, 1'b0));
    // Overvoltage only acts while enabled
    ov_i = 1'b1;
    tick(10);
    st(3'b110);
    wr(GDC_PROT_CFG_ADDR, pc(GDC_MODE_OFF, 2'h0, 1'b0) | 32'h00040000);
    tick(10);
    st(3'b000);
    final_report();
  end

  // Watchdog against a hang
  initial begin
    #200000;
    mismatches++;
    final_report();
  end
endmodule : tb
